// *** pkg/cmav_defs.svh ***
// constants for the mode, address and vector logic
`ifndef CMAV_DEFS_SVH
`define CMAV_DEFS_SVH
`define CMAV_ARCH_W 32
`define CMAV_IMPL_W 24
`define CMAV_NORMAL_EA_W 16
`define CMAV_VEC_BASE 32'h0000_0000
`define CMAV_IND_LAST 32'h0000_00ff
`define CMAV_UPPER_TGT 8'h00
`define CMAV_ST_ADDSUB 5'h01
`define CMAV_ST_MULU_B 5'h0c
`define CMAV_ST_MULU_W 5'h14
`define CMAV_ST_MULS_B 5'h0d
`define CMAV_ST_MULS_W 5'h15
`define CMAV_ST_DIV_B 5'h0c
`define CMAV_ST_DIV_W 5'h14
`define CMAV_ST_W 5
`define CMAV_MD_NORMAL 3'h0
`define CMAV_STEP_W 2'h2
`endif

// *** pkg/cmav_pkg.sv ***
// types for the mode, address and vector logic
package cmav_pkg;
  typedef enum logic {CMAV_MODE_NORMAL, CMAV_MODE_ADVANCED} cmav_mode_t;
  typedef enum logic [1:0]
  {
    CMAV_REQ_CALL,
    CMAV_REQ_CALL_IND,
    CMAV_REQ_JMP_IND,
    CMAV_REQ_EXC
  } cmav_kind_t;
  typedef enum logic [2:0]
  {
    CMAV_OP_ADDSUB,
    CMAV_OP_MULU_B,
    CMAV_OP_MULU_W,
    CMAV_OP_MULS_B,
    CMAV_OP_MULS_W,
    CMAV_OP_DIV_B,
    CMAV_OP_DIV_W
  } cmav_op_t;
  typedef struct packed {
    cmav_kind_t kind;
    logic [7:0] sel;
    logic [23:0] pc;
    logic [7:0] condition_code_reg;
    logic [7:0] extended_control_reg;
    logic exr_valid;
    logic icm0;
    logic [31:0] sp;
  } cmav_req_t;
  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [15:0] wdata;
  } cmav_bus_t;
endpackage

// *** rtl/cmav_state_ctr.sv ***
// execution-state counter for arithmetic operations
`timescale 1ns/1ps
module cmav_state_ctr #(
  parameter int CW = 5
) (
  input wire logic clk, // core clock
  input wire logic nrst, // sync reset, low
  input wire logic start, // begin an operation
  input wire logic [CW-1:0] count, // states it takes
  output logic busy, // operation in progress
  output logic done // last state of the operation
);
  logic [CW-1:0] cnt_q;

  generate
    if (CW < 2)
    begin : g_chk
      $error("cmav_state_ctr: CW too small");
    end
  endgenerate

  // a start while busy is ignored so timing cannot be cut short
  always_ff @(posedge clk)
  begin
    if (!nrst)
      cnt_q <= '0;
    else if (start && cnt_q == '0)
      cnt_q <= count;
    else if (cnt_q != '0)
      cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
  end

  assign busy = (cnt_q != '0);
  assign done = (cnt_q == {{(CW-1){1'b0}}, 1'b1});
endmodule

// *** rtl/cmav_core.sv ***
// mode select, address masking, vector/indirect fetch and stacking
`timescale 1ns/1ps
`include "cmav_defs.svh"
module cmav_core #(
  parameter int NORMAL_OK = 0,
  parameter int IMPL_W = `CMAV_IMPL_W
) (
  input wire logic clk, // core clock
  input wire logic nrst, // sync reset, low
  input wire logic [2:0] mode_pins, // mode pin levels
  output logic mode_adv, // advanced mode in force
  output logic mode_refused, // pins ask for normal mode and NORMAL_OK is 0
  input wire logic [31:0] ea_in, // computed effective address
  output logic [31:0] ea_out, // address seen by memory
  input wire logic ar_upd, // post-inc/pre-dec update
  input wire logic [31:0] ar_in, // address register value
  input wire logic [1:0] ar_size, // 0 byte, 1 word, 2 long
  input wire logic ar_dec, // pre-decrement when high
  output logic [31:0] ar_addr, // address for the access
  output logic [31:0] ar_next, // new register value
  input wire logic [23:0] fetch_pc, // program counter
  output logic [31:0] fetch_addr, // instruction fetch address
  input wire logic req_valid, // stacking/vector request
  input wire cmav_pkg::cmav_req_t req, // request contents
  output logic req_ready, // request taken
  output logic seq_done, // sequence finished
  output logic pc_load_en, // pc_load is valid at seq_done
  output logic [23:0] pc_load, // new program counter
  output logic [31:0] sp_load, // new stack pointer
  output cmav_pkg::cmav_bus_t bus, // internal bus request
  input wire logic bus_ack, // bus cycle complete
  input wire logic [15:0] bus_rdata, // bus read data
  input wire logic op_start, // start an arithmetic op
  input wire cmav_pkg::cmav_op_t op, // which op
  output logic op_busy, // op in progress
  output logic op_done, // op in its last state
  input wire logic sleep_exec, // sleep instruction run
  input wire logic wake, // wake from power-down
  input wire logic [1:0] clk_sel, // divide by 1, 2, 4, 8
  output logic sleeping, // power-down state
  output logic cpu_tick // divided core tick
);
  import cmav_pkg::*;

  typedef enum {S_IDLE, S_PUSH, S_FETCH_HI, S_FETCH_LO, S_DONE} cmav_st_t;

  generate
    if (NORMAL_OK > 1 || IMPL_W < `CMAV_NORMAL_EA_W ||
        IMPL_W > `CMAV_ARCH_W)
    begin : g_chk
      $error("cmav_core: unsupported parameter values");
    end
  endgenerate

  // mode pins: three flops, change accepted when last two agree
  logic [2:0] md1_q, md2_q, md3_q, md_q;
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      md1_q <= 3'h0;
      md2_q <= 3'h0;
      md3_q <= 3'h0;
    end
    else
    begin
      md1_q <= mode_pins;
      md2_q <= md1_q;
      md3_q <= md2_q;
    end
  end

  logic pin_normal;
  always_ff @(posedge clk)
  begin
    if (!nrst)
      md_q <= 3'h7;
    else if (md2_q == md3_q)
      md_q <= md3_q;
  end
  assign pin_normal = (md_q == `CMAV_MD_NORMAL);

  // normal mode would alias low memory; this part runs only advanced unless NORMAL_OK is 1
  cmav_mode_t mode_q;
  always_ff @(posedge clk)
  begin
    if (!nrst)
      mode_q <= CMAV_MODE_ADVANCED;
    else if (pin_normal && NORMAL_OK == 1)
      mode_q <= CMAV_MODE_NORMAL;
    else
      mode_q <= CMAV_MODE_ADVANCED;
  end

  logic adv;
  assign adv = (mode_q == CMAV_MODE_ADVANCED);
  assign mode_adv = adv;
  assign mode_refused = pin_normal && (NORMAL_OK == 0);

  // address masks: 32-bit path, implemented width trims it
  localparam logic [31:0] IMPL_MASK =
    32'hffff_ffff >> (`CMAV_ARCH_W - IMPL_W);
  localparam logic [31:0] NORM_MASK = 32'h0000_ffff;
  logic [31:0] amask;
  assign amask = adv ? IMPL_MASK : NORM_MASK;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      ea_out <= 32'h0;
      fetch_addr <= 32'h0;
    end
    else
    begin
      ea_out <= ea_in & amask;
      fetch_addr <= {8'h00, fetch_pc[23:1], 1'b0} & amask;
    end
  end

  // full 32-bit add so the carry reaches the upper half even in
  // normal mode, where only the address itself is trimmed
  logic [31:0] step;
  logic [31:0] ar_mod;
  always_comb
  begin
    step = 32'h1;
    case (ar_size)
      2'h0: step = 32'h1;
      2'h1: step = 32'h2;
      2'h2: step = 32'h4;
      default: step = 32'h4;
    endcase
  end
  assign ar_mod = ar_dec ? (ar_in - step) : (ar_in + step);

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      ar_addr <= 32'h0;
      ar_next <= 32'h0;
    end
    else if (ar_upd)
    begin
      ar_addr <= (ar_dec ? ar_mod : ar_in) & amask;
      ar_next <= ar_mod;
    end
  end

  // stacking and vector / indirect sequencer
  cmav_st_t st_q;
  cmav_req_t req_q;
  logic [2:0][15:0] words_q;
  logic [1:0] nwords_q;
  logic [1:0] idx_q;
  logic [31:0] sp_q;
  logic [31:0] faddr_q;
  logic [7:0] hi_q;
  logic ld_q;
  logic [23:0] pc_q;
  logic push_exr;
  logic [31:0] vec_addr;
  logic [31:0] ind_addr;
  logic [31:0] tgt_addr;
  logic want_fetch;

  assign push_exr = req.exr_valid && !req.icm0;
  assign vec_addr = adv ? (`CMAV_VEC_BASE | {22'h0, req.sel, 2'b00})
                        : (`CMAV_VEC_BASE | {23'h0, req.sel, 1'b0});
  // indirect entries are word aligned and stay in the low page
  assign ind_addr = {24'h0, req.sel[7:1], 1'b0} & `CMAV_IND_LAST;
  assign tgt_addr = (req.kind == CMAV_REQ_EXC) ? vec_addr
                                               : ind_addr;
  assign want_fetch = (req.kind != CMAV_REQ_CALL);
  assign req_ready = (st_q == S_IDLE) && !sleeping;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      st_q <= S_IDLE;
      req_q <= '0;
      words_q <= '0;
      nwords_q <= 2'h0;
      idx_q <= 2'h0;
      sp_q <= 32'h0;
      faddr_q <= 32'h0;
      hi_q <= 8'h00;
      ld_q <= 1'b0;
      pc_q <= 24'h0;
      bus <= '0;
    end
    else
    begin
      case (st_q)
        S_IDLE:
        begin
          if (req_valid && req_ready)
          begin
            req_q <= req;
            sp_q <= req.sp;
            faddr_q <= tgt_addr;
            ld_q <= want_fetch;
            idx_q <= 2'h0;
            words_q[0] <= req.pc[15:0];
            if (req.kind == CMAV_REQ_EXC)
            begin
              words_q[1] <= adv ? {req.condition_code_reg, req.pc[23:16]}
                                : {req.condition_code_reg, req.condition_code_reg};
              words_q[2] <= adv ? {req.extended_control_reg, 8'h00}
                                : {req.extended_control_reg, req.extended_control_reg};
              nwords_q <= push_exr ? 2'h3 : 2'h2;
            end
            else
            begin
              words_q[1] <= {8'h00, req.pc[23:16]};
              words_q[2] <= 16'h0;
              nwords_q <= adv ? 2'h2 : 2'h1;
            end
            if (req.kind == CMAV_REQ_JMP_IND)
            begin
              st_q <= adv ? S_FETCH_HI : S_FETCH_LO;
              bus.req <= 1'b1;
              bus.we <= 1'b0;
              bus.addr <= tgt_addr & amask;
            end
            else
            begin
              st_q <= S_PUSH;
              bus.req <= 1'b1;
              bus.we <= 1'b1;
              bus.addr <= (req.sp - 32'h2) & amask;
              bus.wdata <= req.pc[15:0];
            end
          end
        end
        S_PUSH:
        begin
          if (bus_ack)
          begin
            sp_q <= sp_q - 32'h2;
            idx_q <= idx_q + 2'h1;
            if (idx_q + 2'h1 == nwords_q)
            begin
              if (ld_q)
              begin
                st_q <= adv ? S_FETCH_HI : S_FETCH_LO;
                bus.we <= 1'b0;
                bus.addr <= faddr_q & amask;
              end
              else
              begin
                st_q <= S_DONE;
                bus <= '0;
              end
            end
            else
            begin
              bus.addr <= (sp_q - 32'h4) & amask;
              bus.wdata <= words_q[idx_q + 2'h1];
            end
          end
        end
        S_FETCH_HI:
        begin
          if (bus_ack)
          begin
            hi_q <= bus_rdata[7:0];
            st_q <= S_FETCH_LO;
            bus.addr <= (faddr_q + 32'h2) & amask;
          end
        end
        S_FETCH_LO:
        begin
          if (bus_ack)
          begin
            pc_q <= adv ? {hi_q, bus_rdata}
                        : {`CMAV_UPPER_TGT, bus_rdata};
            st_q <= S_DONE;
            bus <= '0;
          end
        end
        S_DONE:
        begin
          st_q <= S_IDLE;
        end
        default:
        begin
          st_q <= S_IDLE;
          bus <= '0;
        end
      endcase
    end
  end

  assign seq_done = (st_q == S_DONE);
  assign pc_load_en = seq_done && ld_q;
  assign pc_load = pc_q;
  assign sp_load = sp_q;

  // execution states per operation
  logic [`CMAV_ST_W-1:0] op_states;
  always_comb
  begin
    op_states = `CMAV_ST_ADDSUB;
    case (op)
      CMAV_OP_ADDSUB: op_states = `CMAV_ST_ADDSUB;
      CMAV_OP_MULU_B: op_states = `CMAV_ST_MULU_B;
      CMAV_OP_MULU_W: op_states = `CMAV_ST_MULU_W;
      CMAV_OP_MULS_B: op_states = `CMAV_ST_MULS_B;
      CMAV_OP_MULS_W: op_states = `CMAV_ST_MULS_W;
      CMAV_OP_DIV_B: op_states = `CMAV_ST_DIV_B;
      CMAV_OP_DIV_W: op_states = `CMAV_ST_DIV_W;
      default: op_states = `CMAV_ST_ADDSUB;
    endcase
  end

  cmav_state_ctr #(
    .CW(`CMAV_ST_W)
  ) u_states (
    .clk(clk),
    .nrst(nrst),
    .start(op_start && !sleeping),
    .count(op_states),
    .busy(op_busy),
    .done(op_done)
  );

  // power-down: a sleep in the same cycle as a wake still sleeps
  logic sleep_q;
  always_ff @(posedge clk)
  begin
    if (!nrst)
      sleep_q <= 1'b0;
    else if (sleep_exec)
      sleep_q <= 1'b1;
    else if (wake)
      sleep_q <= 1'b0;
  end
  assign sleeping = sleep_q;

  // divided tick; counter cleared and tick held low while asleep to save toggling
  logic [2:0] div_q;
  logic [2:0] div_max;
  logic tick_q;
  always_comb
  begin
    div_max = 3'h0;
    case (clk_sel)
      2'h0: div_max = 3'h0;
      2'h1: div_max = 3'h1;
      2'h2: div_max = 3'h3;
      default: div_max = 3'h7;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      div_q <= 3'h0;
      tick_q <= 1'b0;
    end
    else if (sleep_q)
    begin
      div_q <= 3'h0;
      tick_q <= 1'b0;
    end
    else if (div_q >= div_max)
    begin
      div_q <= 3'h0;
      tick_q <= 1'b1;
    end
    else
    begin
      div_q <= div_q + 3'h1;
      tick_q <= 1'b0;
    end
  end
  assign cpu_tick = tick_q;
endmodule

// *** test/cmav_core_asserts.sv ***
// assertions on the core's mode, address, op and sequence outputs
`timescale 1ns/1ps
module cmav_core_asserts #(
  parameter int IMPL_W = 24
) (
  input wire logic clk, // core clock
  input wire logic nrst, // sync reset, low
  input wire logic [2:0] mode_pins, // mode pins
  input wire logic mode_adv, // advanced mode
  input wire logic mode_refused, // normal refused
  input wire logic [31:0] ea_in, // address in
  input wire logic [31:0] ea_out, // address out
  input wire logic [23:0] fetch_pc, // pc
  input wire logic [31:0] fetch_addr, // fetch address
  input wire logic req_valid, // request
  input wire logic req_ready, // request taken
  input wire logic seq_done, // sequence end
  input wire logic pc_load_en, // pc load
  input wire cmav_pkg::cmav_bus_t bus, // bus
  input wire logic bus_ack, // bus ack
  input wire logic op_start, // op start
  input wire cmav_pkg::cmav_op_t op, // op
  input wire logic op_busy, // op busy
  input wire logic op_done, // op last
  input wire logic sleep_exec, // sleep
  input wire logic sleeping, // asleep
  input wire logic cpu_tick // tick
);
  import cmav_pkg::*;
  localparam logic [31:0] MASK = (32'h1 << IMPL_W) - 32'h1;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_add_go;
    op_start && !op_busy && !sleeping && op == CMAV_OP_ADDSUB;
  endsequence
  sequence s_one_state;
    op_busy && op_done ##1 !op_busy;
  endsequence
  a_ea_mask:
    assert property ($past(nrst) |-> ea_out == ($past(ea_in) & MASK))
    else $error("address not masked");
  a_fetch_even:
    assert property ($past(nrst) |->
      fetch_addr == ({8'h00, $past(fetch_pc)} & MASK & ~32'h1))
    else $error("fetch address wrong");
  // pins pass a synchroniser, so they must sit still before judging
  a_pin_mode:
    assert property ($stable(mode_pins) [*8] |->
      mode_adv && mode_refused == (mode_pins == 3'h0))
    else $error("mode does not follow pins");
  a_addsub_one:
    assert property (s_add_go |=> s_one_state)
    else $error("add or subtract not one state");
  a_done_pulse:
    assert property ((pc_load_en |-> seq_done) and (seq_done |=> !seq_done))
    else $error("sequence end not a pulse");
  a_bus_hold:
    assert property (bus.req && !bus_ack |=>
      bus.req && $stable(bus.addr) && $stable(bus.wdata))
    else $error("bus word dropped before ack");
  a_take_busy:
    assert property (req_valid && req_ready |=> !req_ready)
    else $error("request taken while busy");
  a_sleep_enter:
    assert property (sleep_exec |=> sleeping)
    else $error("sleep not entered");
  a_tick_quiet:
    assert property (sleeping && $past(sleeping) |-> !cpu_tick)
    else $error("tick while asleep");
endmodule
bind cmav_core cmav_core_asserts #(.IMPL_W(IMPL_W)) u_chk (
  .clk(clk), .nrst(nrst), .mode_pins(mode_pins), .mode_adv(mode_adv),
  .mode_refused(mode_refused), .ea_in(ea_in), .ea_out(ea_out),
  .fetch_pc(fetch_pc), .fetch_addr(fetch_addr), .req_valid(req_valid),
  .req_ready(req_ready), .seq_done(seq_done), .pc_load_en(pc_load_en),
  .bus(bus), .bus_ack(bus_ack), .op_start(op_start), .op(op),
  .op_busy(op_busy), .op_done(op_done), .sleep_exec(sleep_exec),
  .sleeping(sleeping), .cpu_tick(cpu_tick)
);

// *** test/cmav_mem_model.sv ***
// memory model answering the core's internal bus
`timescale 1ns/1ps
module cmav_mem_model (
  input wire logic clk, // core clock
  input wire logic nrst, // sync reset, low
  input wire cmav_pkg::cmav_bus_t bus, // bus request
  input wire logic [1:0] lag, // wait states per word
  output logic bus_ack, // word complete
  output logic [15:0] bus_rdata // read data
);
  import cmav_pkg::*;
  logic [15:0] mem [256];
  logic [1:0] wait_q;
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = {~i[7:0], i[7:0]};
  end
  assign bus_ack = bus.req && wait_q == lag;
  // data off the ack is inverted so a late sample cannot match
  assign bus_rdata = bus_ack ? mem[bus.addr[8:1]] : ~mem[bus.addr[8:1]];
  always @(posedge clk)
  begin
    if (!nrst || bus_ack)
      wait_q <= 2'h0;
    else if (bus.req)
      wait_q <= wait_q + 2'h1;
    if (bus_ack && bus.we)
      mem[bus.addr[8:1]] <= bus.wdata;
  end
endmodule

// *** test/cmav_core_tb_top.sv ***
// self-checking bench for the mode, address and sequencing logic
`timescale 1ns/1ps
module cmav_core_tb_top;
  import cmav_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] mode_pins = 3'h7;
  logic mode_adv, mode_refused, req_ready, seq_done, pc_load_en, bus_ack;
  logic ar_upd, ar_dec, req_valid, op_start, op_busy, op_done;
  logic sleep_exec, wake, sleeping, cpu_tick;
  logic [31:0] ea_in, ea_out, ar_in, ar_addr, ar_next, fetch_addr, sp_load;
  logic [31:0] a, e;
  logic [1:0] ar_size, clk_sel, lag;
  logic [23:0] fetch_pc, pc_load;
  logic [15:0] bus_rdata;
  cmav_req_t req;
  cmav_bus_t bus;
  cmav_op_t op;
  int n_mismatch, checks, n;
  int st [7] = '{1, 12, 20, 13, 21, 12, 20};
  always #20 clk = ~clk;
  cmav_core #(.NORMAL_OK(0), .IMPL_W(24)) uut (.clk(clk), .nrst(nrst),
    .mode_pins(mode_pins), .mode_adv(mode_adv), .mode_refused(mode_refused),
    .ea_in(ea_in), .ea_out(ea_out), .ar_upd(ar_upd), .ar_in(ar_in),
    .ar_size(ar_size), .ar_dec(ar_dec), .ar_addr(ar_addr),
    .ar_next(ar_next), .fetch_pc(fetch_pc), .fetch_addr(fetch_addr),
    .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .seq_done(seq_done), .pc_load_en(pc_load_en), .pc_load(pc_load),
    .sp_load(sp_load), .bus(bus), .bus_ack(bus_ack), .bus_rdata(bus_rdata),
    .op_start(op_start), .op(op), .op_busy(op_busy), .op_done(op_done),
    .sleep_exec(sleep_exec), .wake(wake), .clk_sel(clk_sel),
    .sleeping(sleeping), .cpu_tick(cpu_tick));
  cmav_mem_model u_mem (.clk(clk), .nrst(nrst), .bus(bus), .lag(lag),
    .bus_ack(bus_ack), .bus_rdata(bus_rdata));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // memory word as the model preloads it
  function automatic logic [15:0] mw(input logic [31:0] ad);
    mw = {~ad[8:1], ad[8:1]};
  endfunction
  // called at an edge; a new request may follow the done pulse at once
  task automatic seq(input cmav_kind_t k);
    cmav_req_t r;
    int w;
    logic ok;
    logic [31:0] ad;
    r = {k, 8'($urandom), 24'($urandom), 16'($urandom), 2'($urandom),
      $urandom & 32'hffff_fe00};
    if (k == CMAV_REQ_EXC)
      r.sel = r.sel & 8'h3f;
    ad = (k == CMAV_REQ_EXC) ? {r.sel, 2'h0} : {r.sel[7:1], 1'b0};
    w = (k == CMAV_REQ_JMP_IND) ? 0 : 2;
    if (k == CMAV_REQ_EXC && r.exr_valid && !r.icm0)
      w = 3;
    lag <= 2'($urandom);
    req_valid <= 1'b1;
    req <= r;
    n = 0;
    // ready is judged before the edge that takes the request
    do
    begin
      #1;
      ok = req_ready;
      @(posedge clk);
      n++;
    end
    while (ok !== 1'b1 && n < 40);
    if (ok !== 1'b1)
      chk(32'h0, 32'h1);
    req_valid <= 1'b0;
    for (n = 0; n < 60 && seq_done !== 1'b1; n++)
    begin
      @(posedge clk);
      #1;
    end
    if (n == 60)
      chk(32'h0, 32'h1);
    chk(sp_load, r.sp - 32'(2 * w));
    chk(pc_load_en, k != CMAV_REQ_CALL);
    if (k != CMAV_REQ_CALL)
      chk(pc_load, {ad[8:1], mw(ad + 32'h2)});
    if (w > 0)
      chk(u_mem.mem[8'hff], r.pc[15:0]);
    if (w > 0)
      chk(u_mem.mem[8'hfe], {k == CMAV_REQ_EXC ? r.condition_code_reg : 8'h0, r.pc[23:16]});
    if (w == 3)
      chk(u_mem.mem[8'hfd], {r.extended_control_reg, 8'h00});
  endtask
  initial
  begin
    {ar_upd, ar_dec, req_valid, op_start, sleep_exec, wake} = 6'h0;
    {ea_in, ar_in, fetch_pc, ar_size, clk_sel, lag} = 94'h0;
    req = 84'h0;
    op = CMAV_OP_ADDSUB;
    n_mismatch = 0;
    checks = 0;
    n = $urandom(32'h20ee35ba);
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    mode_pins <= 3'h0;
    repeat (10) @(posedge clk);
    chk({mode_adv, mode_refused}, 2'h3);
    mode_pins <= 3'h5;
    repeat (10) @(posedge clk);
    chk({mode_adv, mode_refused}, 2'h2);
    $display("mode test over");
    for (int i = 0; i < 40; i++)
    begin
      @(posedge clk);
      a = (i == 0) ? 32'hffff : (i == 1) ? 32'h10000 : $urandom;
      ea_in <= a;
      fetch_pc <= a[23:0];
      ar_in <= a;
      ar_size <= (i == 1) ? 2'h2 : (i == 0) ? 2'h0 : 2'($urandom);
      ar_dec <= (i < 2) ? i[0] : 1'($urandom);
      ar_upd <= 1'b1;
      @(posedge clk);
      #1;
      e = 32'h1 << ((ar_size == 2'h3) ? 2'h2 : ar_size);
      chk(ea_out, a & 32'hff_ffff);
      chk(fetch_addr, {8'h0, a[23:1], 1'b0});
      chk(ar_next, ar_dec ? a - e : a + e);
      chk(ar_addr, (ar_dec ? a - e : a) & 32'hff_ffff);
    end
    $display("address test over");
    @(posedge clk);
    for (int i = 0; i < 24; i++)
      seq(cmav_kind_t'(i % 4));
    $display("sequence test over");
    for (int i = 0; i < 7; i++)
    begin
      @(posedge clk);
      op_start <= 1'b1;
      op <= cmav_op_t'(i);
      @(posedge clk);
      op_start <= 1'b0;
      e = 0;
      // count busy cycles, sampling each one after its edge settles
      for (n = 0; n < 40; n++)
      begin
        #1;
        if (op_busy !== 1'b1)
          break;
        e = op_done;
        @(posedge clk);
      end
      chk(n, st[i]);
      chk(e, 1);
    end
    $display("op test over");
    for (int s = 0; s < 4; s++)
    begin
      clk_sel <= 2'(s);
      n = 0;
      repeat (64) @(posedge clk) n += cpu_tick;
      chk(n >= (64 >> s) - 1 && n <= (64 >> s) + 1, 1);
    end
    sleep_exec <= 1'b1;
    wake <= 1'b1;
    @(posedge clk);
    {sleep_exec, wake} <= 2'h0;
    @(posedge clk);
    n = 0;
    repeat (16) @(posedge clk) n += cpu_tick;
    chk({sleeping, req_ready, 6'(n)}, 8'h80);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    repeat (2) @(posedge clk);
    chk(sleeping, 0);
    $display("sleep test over");
    close_out();
  end
endmodule
